// File: logic/svw_top.sv
// svw_top.sv: reset generation with manual reset, supply trip and watchdog
// manual reset, kick and supply pins are asynchronous and pass two flops; one 25 MHz clock
// What this block does
// - manual reset low for the delay time forces reset outputs active.
// - after manual reset, hold reset one full delay period.
// - manual reset low pulses under 100 ns never cause reset.
// - watchdog stays off until a falling kick edge arms it.
// - while armed, any kick edge restarts the period.
// - armed period expiring with no edge forces reset.
// - watchdog disabled at power up, reset, timeout, manual reset.
// - kick pull-up on while disabled, off once armed.
// - period is one of four build options, standard 1.6 s.
// - reset beyond maximum gap, never below minimum gap.
// - supply below trip forces reset outputs active.
// - delay timer expiry releases reset; standard 200 ms.
`timescale 1ns/1ns
`default_nettype none
`include "svw_consts.svh"
module svw_top
  import svw_pkg::*;
#(
  parameter int unsigned WD_SEL = `SVW_WD_SEL_STD,
  parameter int unsigned RST_CYC = `SVW_RST_MS * 1000 * `SVW_CYC_PER_US,
  parameter int unsigned MRD_CYC = `SVW_MRD_US * `SVW_CYC_PER_US,
  parameter longint unsigned WD_CYC =
    (WD_SEL == 0) ? longint'(`SVW_WD_US_0) * `SVW_CYC_PER_US :
    (WD_SEL == 1) ? longint'(`SVW_WD_US_1) * `SVW_CYC_PER_US :
    (WD_SEL == 2) ? longint'(`SVW_WD_US_2) * `SVW_CYC_PER_US :
    longint'(`SVW_WD_US_3) * `SVW_CYC_PER_US
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic MANUAL_RESET_N,
  input wire logic WATCHDOG_KICK_INPUT,
  input wire logic SUPPLY_LOW,
  output logic RESET_OUT_N,
  output logic RESET_OUT,
  output logic KICK_PULLUP_EN
);
  localparam int unsigned RW = $clog2(RST_CYC + 1);
  localparam int unsigned WW = $clog2(WD_CYC + 1);
  localparam logic [RW-1:0] RST_LAST = RW'(RST_CYC - 1);
  localparam logic [WW-1:0] WD_LAST = WW'(WD_CYC - 1);

  svw_filter_if mr_if ();
  svw_wd_state_t wd_state;
  svw_wd_state_t next_wd_state;
  svw_cause_t cause;
  logic [1:0] mr_sync;
  logic [1:0] kick_sync;
  logic [1:0] sup_sync;
  logic kick_prev;
  logic [RW-1:0] rst_count;
  logic [WW-1:0] wd_count;
  logic mr_held_prev;

  // two-flop synchronisers for the manual reset, kick and supply pins
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mr_sync <= 2'h3;
      kick_sync <= 2'h3;
      sup_sync <= 2'h3;
    end else begin
      mr_sync <= {mr_sync[0], MANUAL_RESET_N};
      kick_sync <= {kick_sync[0], WATCHDOG_KICK_INPUT};
      sup_sync <= {sup_sync[0], SUPPLY_LOW};
    end
  end

  assign mr_if.raw_n = mr_sync[1];
  svw_filter #(.DELAY_CYC(MRD_CYC)) u_filter (
    .CORE_CLK(CORE_CLK),
    .RESET_N(RESET_N),
    .port_if(mr_if)
  );

  // edge detection on the synchronised kick
  wire kick_fall = kick_prev && !kick_sync[1];
  wire kick_edge = kick_prev != kick_sync[1];
  wire supply_low = sup_sync[1];
  wire manual_hit = mr_if.held;
  wire manual_event = manual_hit && !mr_held_prev;
  wire wd_expire = (wd_state == SVW_WD_ARMED) && !kick_edge && (wd_count == WD_LAST);
  wire any_cause = supply_low || manual_hit || wd_expire;
  wire in_reset = cause != SVW_CAUSE_NONE;
  wire rst_done = in_reset && !any_cause && (rst_count == RST_LAST);

  // watchdog state selection
  always_comb begin
    next_wd_state = wd_state;
    unique case (wd_state)
      SVW_WD_OFF: begin
        if (kick_fall && !in_reset && !any_cause) next_wd_state = SVW_WD_ARMED;
      end
      SVW_WD_ARMED: begin
        if (wd_expire) next_wd_state = SVW_WD_FIRED;
        else if (supply_low || manual_hit) next_wd_state = SVW_WD_OFF;
      end
      SVW_WD_FIRED: begin
        if (rst_done) next_wd_state = SVW_WD_OFF;
      end
      default: next_wd_state = SVW_WD_OFF;
    endcase
  end

  // watchdog state and period counter
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wd_state <= SVW_WD_OFF;
      wd_count <= '0;
      kick_prev <= 1'b1;
      mr_held_prev <= 1'b0;
    end else begin
      wd_state <= next_wd_state;
      kick_prev <= kick_sync[1];
      mr_held_prev <= manual_hit;
      if (wd_state != SVW_WD_ARMED || kick_edge) wd_count <= '0;
      else if (wd_count != WD_LAST) wd_count <= wd_count + WW'(1);
    end
  end

  // reset delay timer restarts while any cause stands
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cause <= SVW_CAUSE_SUPPLY;
      rst_count <= '0;
    end else if (supply_low) begin
      cause <= SVW_CAUSE_SUPPLY;
      rst_count <= '0;
    end else if (manual_hit) begin
      cause <= SVW_CAUSE_MANUAL;
      rst_count <= '0;
    end else if (wd_expire) begin
      cause <= SVW_CAUSE_WATCHDOG;
      rst_count <= '0;
    end else if (rst_done) begin
      cause <= SVW_CAUSE_NONE;
      rst_count <= '0;
    end else if (in_reset) begin
      rst_count <= rst_count + RW'(1);
    end
  end

  // output registers
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESET_OUT_N <= 1'b0;
      RESET_OUT <= 1'b1;
      KICK_PULLUP_EN <= 1'b1;
    end else begin
      RESET_OUT_N <= !(any_cause || (in_reset && !rst_done));
      RESET_OUT <= any_cause || (in_reset && !rst_done);
      KICK_PULLUP_EN <= next_wd_state != SVW_WD_ARMED;
    end
  end

  // observation counters for the checks below, kept apart from the timers
  localparam logic [RW-1:0] RST_FULL = RW'(RST_CYC);
  localparam logic [WW-1:0] WD_FULL = WW'(WD_CYC);
  logic [RW-1:0] quiet_run;
  logic [WW-1:0] since_kick;

  // quiet_run counts held cycles with no cause; since_kick counts armed cycles
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      quiet_run <= '0;
      since_kick <= '0;
    end else begin
      if (any_cause || RESET_OUT_N) quiet_run <= '0;
      else if (quiet_run != RST_FULL) quiet_run <= quiet_run + RW'(1);
      if (wd_state != SVW_WD_ARMED || kick_edge) since_kick <= '0;
      else if (since_kick != WD_FULL) since_kick <= since_kick + WW'(1);
    end
  end

  // both reset pins always complementary
  a_outputs_inverse: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    RESET_OUT == !RESET_OUT_N)
    else $error("reset outputs not complementary");
  // held manual reset reaches the pins next edge
  a_manual_forces: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    manual_hit |=> !RESET_OUT_N)
    else $error("manual reset not applied");
  // supply trip reaches the pins next edge
  a_supply_forces: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    supply_low |=> !RESET_OUT_N)
    else $error("supply trip not applied");
  // expiry drives reset and leaves the watchdog fired
  a_expire_forces: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wd_expire |=> !RESET_OUT_N && wd_state == SVW_WD_FIRED)
    else $error("timeout no reset");
  // only a falling kick arms
  a_arm_needs_fall: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(wd_state == SVW_WD_ARMED) |-> $past(kick_fall))
    else $error("armed without fall");
  // any kick edge restarts the period
  a_kick_restarts: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (wd_state == SVW_WD_ARMED && kick_edge) |=> wd_count == '0)
    else $error("kick ignored");
  // pull-up follows the armed state
  a_pullup_tracks: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    KICK_PULLUP_EN == (wd_state != SVW_WD_ARMED))
    else $error("pull-up wrong");
  // release only when the delay timer ends
  a_release_after: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(RESET_OUT_N) |-> $past(rst_done))
    else $error("release without delay expiry");
  // manual event disarms the watchdog
  a_manual_off: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    manual_event |=> wd_state != SVW_WD_ARMED)
    else $error("watchdog kept after manual");

  // release comes after a full quiet delay period
  a_hold_full: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(RESET_OUT_N) |-> quiet_run == RST_FULL)
    else $error("reset released early");
  // release is not late once the delay has run out
  a_release_due: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (quiet_run == RST_LAST && !any_cause && !RESET_OUT_N) |=> RESET_OUT_N)
    else $error("reset released late");
  // released pins stay released while no cause stands
  a_idle_stays: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (RESET_OUT_N && !any_cause) |=> RESET_OUT_N)
    else $error("reset without cause");
  // expiry only when the full period passed without an edge
  a_fire_at_period: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wd_expire |-> since_kick == WD_LAST)
    else $error("expiry at wrong count");
  // no expiry while the gap is short
  a_no_early_fire: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (wd_state == SVW_WD_ARMED && since_kick < WD_LAST) |-> !wd_expire)
    else $error("early expiry");
  // expiry is never skipped
  a_fire_when_due: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (wd_state == SVW_WD_ARMED && since_kick == WD_LAST && !kick_edge) |-> wd_expire)
    else $error("expiry missed");
  // a fired watchdog keeps its pull-up on
  a_fired_pullup: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wd_state == SVW_WD_FIRED |-> KICK_PULLUP_EN)
    else $error("pull-up off after timeout");
  // a fired watchdog never goes straight to armed
  a_fired_not_armed: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wd_state == SVW_WD_FIRED |=> wd_state != SVW_WD_ARMED)
    else $error("rearmed from timeout");
  // end of the delay leaves the watchdog off
  a_fired_leaves: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (wd_state == SVW_WD_FIRED && rst_done) |=> wd_state == SVW_WD_OFF)
    else $error("watchdog not off after delay");
  // reset pins held while the watchdog is fired
  a_fired_holds: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wd_state == SVW_WD_FIRED |-> !RESET_OUT_N)
    else $error("timeout reset not held");
  // rising kick or no edge never arms
  a_rise_no_arm: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (wd_state == SVW_WD_OFF && !kick_fall) |=> wd_state != SVW_WD_ARMED)
    else $error("armed without falling kick");
  // no arming while reset is held
  a_arm_not_in_reset: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (wd_state == SVW_WD_OFF && in_reset) |=> wd_state == SVW_WD_OFF)
    else $error("armed during reset");
  // supply trip disarms the watchdog
  a_supply_disarms: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (wd_state == SVW_WD_ARMED && !wd_expire && supply_low) |=> wd_state == SVW_WD_OFF)
    else $error("watchdog kept after supply trip");
  // any cause drives the active-high pin
  a_cause_high: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    any_cause |=> RESET_OUT)
    else $error("active-high reset not applied");
  // armed only while no reset is pending
  a_armed_free: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wd_state == SVW_WD_ARMED |-> !in_reset)
    else $error("armed during reset hold");
  // armed watchdog sees released pins
  a_armed_released: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wd_state == SVW_WD_ARMED |-> RESET_OUT_N)
    else $error("armed with reset active");
  // period counter never passes its last value
  a_count_bounded: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wd_count <= WD_LAST)
    else $error("period counter overrun");
  // delay counter never passes its last value
  a_timer_bounded: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    rst_count <= RST_LAST)
    else $error("delay counter overrun");
endmodule
`default_nettype wire

// File: logic/svw_consts.svh
// svw_consts.svh: clock, filter, delay and watchdog timing counts for the supervisor watchdog
// assumes a 25 MHz core clock; included by bare name
`ifndef SVW_CONSTS_SVH
`define SVW_CONSTS_SVH
// core clock period in ns
`define SVW_CLK_NS 40
// manual reset glitch filter, ns, and its cycle count (rounded up)
`define SVW_GLITCH_NS 100
`define SVW_GLITCH_CYC ((`SVW_GLITCH_NS + `SVW_CLK_NS - 1) / `SVW_CLK_NS)
// manual reset delay, in us
`define SVW_MRD_US 100
// reset delay timer typical, ms
`define SVW_RST_MS 200
// watchdog period options, typical, us
`define SVW_WD_US_0 6300
`define SVW_WD_US_1 102000
`define SVW_WD_US_2 1600000
`define SVW_WD_US_3 25600000
// standard watchdog option index
`define SVW_WD_SEL_STD 2
// cycles per us at 25 MHz
`define SVW_CYC_PER_US (1000 / `SVW_CLK_NS)
`endif

// File: logic/svw_pkg.sv
// svw_pkg.sv: types for the supervisor watchdog
// no dependencies
package svw_pkg;
  // watchdog state
  typedef enum logic [1:0] {
    SVW_WD_OFF = 2'b00,
    SVW_WD_ARMED = 2'b01,
    SVW_WD_FIRED = 2'b10
  } svw_wd_state_t;
  // cause held by the reset delay timer
  typedef enum logic [1:0] {
    SVW_CAUSE_NONE = 2'b00,
    SVW_CAUSE_SUPPLY = 2'b01,
    SVW_CAUSE_MANUAL = 2'b10,
    SVW_CAUSE_WATCHDOG = 2'b11
  } svw_cause_t;
endpackage

// File: logic/svw_filter_if.sv
// svw_filter_if.sv: carries the filtered manual reset from the filter to the top
// one clock domain, driven by svw_filter
`timescale 1ns/1ns
`default_nettype none
interface svw_filter_if;
  logic raw_n;
  logic held;
  modport filt (input raw_n, output held);
  modport user (output raw_n, input held);
endinterface
`default_nettype wire

// File: logic/svw_filter.sv
// svw_filter.sv: glitch filter and delay for the manual reset input
// raw input is already synchronised by the top module
`timescale 1ns/1ns
`default_nettype none
`include "svw_consts.svh"
module svw_filter
  import svw_pkg::*;
#(
  parameter int unsigned DELAY_CYC = `SVW_MRD_US * `SVW_CYC_PER_US
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  svw_filter_if.filt port_if
);
  localparam int unsigned W = $clog2(DELAY_CYC + 1);
  localparam logic [W-1:0] GLITCH = W'(`SVW_GLITCH_CYC);
  localparam logic [W-1:0] LIMIT = W'(DELAY_CYC);
  logic [W-1:0] low_count;
  logic held;
  wire at_limit = (low_count >= LIMIT) && (low_count >= GLITCH);
  // count continuous low time; any high sample restarts
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      low_count <= '0;
      held <= 1'b0;
    end else if (port_if.raw_n) begin
      low_count <= '0;
      held <= 1'b0;
    end else begin
      if (!at_limit) low_count <= low_count + W'(1);
      held <= at_limit;
    end
  end
  assign port_if.held = held;
  // short pulse never reaches held
  a_glitch_blocked: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(held) |-> $past(!port_if.raw_n, 2))
    else $error("held without low input");
endmodule
`default_nettype wire

// File: tb/svw_host.sv
// svw_host.sv: host model that services the watchdog kick pin
// runs on the core clock; the bench sets enable and gap
`timescale 1ns/1ns
`default_nettype none
module svw_host (
  input wire logic clk,
  input wire logic en,
  input wire logic [7:0] gap,
  output logic kick
);
  logic [7:0] cnt;
  initial kick = 1'b1;
  // idle high like the pull-up; toggle every gap+1 cycles
  always @(posedge clk) begin
    if (!en) begin
      cnt <= 8'h00;
      kick <= 1'b1;
    end else if (cnt >= gap) begin
      cnt <= 8'h00;
      kick <= ~kick;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: tb/svw_top_bench.sv
// svw_top_bench.sv: self-checking bench for the reset supervisor
// uses svw_host as the kick source; short counts via parameters
`timescale 1ns/1ns
`default_nettype none
module svw_top_bench;
  localparam int RST = 50;
  localparam int MRD = 10;
  localparam int WD = 100;
  logic CORE_CLK, RESET_N, MANUAL_RESET_N, SUPPLY_LOW;
  logic RESET_OUT_N, RESET_OUT, KICK_PULLUP_EN, kick, en;
  logic [7:0] gap;
  int error_cnt, comparisons, c;
  svw_top #(.RST_CYC(RST), .MRD_CYC(MRD), .WD_CYC(WD)) i_dut (
    .CORE_CLK(CORE_CLK),
    .RESET_N(RESET_N),
    .MANUAL_RESET_N(MANUAL_RESET_N),
    .WATCHDOG_KICK_INPUT(kick),
    .SUPPLY_LOW(SUPPLY_LOW),
    .RESET_OUT_N(RESET_OUT_N),
    .RESET_OUT(RESET_OUT),
    .KICK_PULLUP_EN(KICK_PULLUP_EN)
  );
  svw_host i_host (.clk(CORE_CLK), .en(en), .gap(gap), .kick(kick));
  // clock at 25 MHz
  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end
  task automatic close_out();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  // bounded wait for a reset level, cycles used in c
  task automatic wait_rst(input logic v, input int n);
    c = 0;
    while (RESET_OUT_N !== v && c < n) begin
      cyc(1);
      c++;
    end
    if (c >= n) begin
      chk(1'b0, 1'b1);
      close_out();
    end
  endtask
  task automatic t_glitch(input int w);
    @(posedge CORE_CLK) MANUAL_RESET_N <= 1'b0;
    repeat (w) @(posedge CORE_CLK);
    MANUAL_RESET_N <= 1'b1;
    cyc(RST);
    chk(RESET_OUT_N, 1'b1);
  endtask
  task automatic t_arm();
    @(posedge CORE_CLK) en <= 1'b1;
    cyc(40);
    chk(KICK_PULLUP_EN, 1'b0);
    cyc(4 * WD);
    chk(RESET_OUT_N, 1'b1);
  endtask
  task automatic t_timeout();
    @(posedge CORE_CLK) en <= 1'b0;
    wait_rst(1'b0, WD + 10);
    chk(c > WD - 25, 1'b1);
    wait_rst(1'b1, RST + 10);
    chk(c >= RST - 1, 1'b1);
    chk(KICK_PULLUP_EN, 1'b1);
    cyc(3 * WD);
    chk(RESET_OUT_N, 1'b1);
  endtask
  task automatic t_manual();
    @(posedge CORE_CLK) MANUAL_RESET_N <= 1'b0;
    wait_rst(1'b0, MRD + 10);
    chk(c >= MRD, 1'b1);
    en <= 1'b0;
    cyc(5);
    MANUAL_RESET_N <= 1'b1;
    wait_rst(1'b1, RST + 10);
    chk(c >= RST, 1'b1);
    chk(KICK_PULLUP_EN, 1'b1);
  endtask
  task automatic t_supply();
    @(posedge CORE_CLK) SUPPLY_LOW <= 1'b1;
    wait_rst(1'b0, 8);
    cyc(RST + 20);
    chk(RESET_OUT_N, 1'b0);
    SUPPLY_LOW <= 1'b0;
    wait_rst(1'b1, RST + 10);
    chk(c >= RST, 1'b1);
  endtask
  // complementary outputs compared every cycle
  always @(negedge CORE_CLK) begin
    if (RESET_N) chk(RESET_OUT, ~RESET_OUT_N);
  end
  // main sequence
  initial begin
    RESET_N = 1'b0;
    MANUAL_RESET_N = 1'b1;
    SUPPLY_LOW = 1'b0;
    en = 1'b0;
    gap = 8'h14;
    cyc(20);
    chk(RESET_OUT_N, 1'b0);
    chk(KICK_PULLUP_EN, 1'b1);
    @(posedge CORE_CLK) RESET_N <= 1'b1;
    wait_rst(1'b1, RST + 10);
    chk(c >= RST, 1'b1);
    t_glitch(2);
    t_glitch(MRD - 3);
    t_arm();
    t_timeout();
    t_arm();
    t_manual();
    t_supply();
    close_out();
  end
endmodule
`default_nettype wire
